// file: logic/spcf_addr_match.sv
`timescale 1ns/10ps
module spcf_addr_match (
   input  wire logic [7:0] byte_in,
   input  wire logic [7:0] node_address_in,
   input  wire logic [7:0] node_address_mask_in,
   output logic            match_out
);
   logic given_hit;
   logic broadcast_hit;
   logic [7:0] broadcast_addr;

   // Mask zeros are don't-care for the given address
   assign given_hit      = ((byte_in ^ node_address_in) & node_address_mask_in) == 8'h00;
   // Zeros of the OR are don't-care for broadcast
   assign broadcast_addr = node_address_in | node_address_mask_in;
   assign broadcast_hit  = ((~byte_in) & broadcast_addr) == 8'h00;
   assign match_out      = given_hit || broadcast_hit;
endmodule : spcf_addr_match

// file: logic/spcf_core.sv
`timescale 1ns/10ps
// How it works
// - Invalid stop bit at frame end sets framing error flag, shown on bit 7.
// - Framing error stays set across good frames; only software writing zero clears it.
// - Bit 7 is framing flag when framing select set, else mode select low.
// - Framing detection ignores baud doubler and current bit 7 function.
// - Modes 2 and 3 capture received ninth data bit.
// - Mode 1 without filtering captures stop bit; mode 0 leaves field unused.
// - Transmit done set at stop bit start outside mode 0; software clears.
// - Receive done at eighth bit end in mode 0, mid stop bit otherwise.
// - Rejected frames do not set receive done; only software clears it.
// - Filtered 9-bit modes need ninth bit one and address match.
// - Filtered mode 1 needs valid stop bit and address match.
// - Given address uses mask; broadcast is address OR mask.
// - Mode 0 ignores filtering enable.
module spcf_core (
   input  wire logic       clock_in,
   input  wire logic       rstn_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       write_in,
   input  wire logic       read_in,
   input  wire logic [7:0] bit_sel_in,
   input  wire logic       bit_write_in,
   output logic [7:0]      rdata_out,
   input  wire logic       tx_stop_start_in,
   input  wire logic       rx_sample_in,
   input  wire logic [7:0] rx_byte_in,
   input  wire logic       rx_ninth_in,
   input  wire logic       rx_stop_in,
   output logic [1:0]      mode_out,
   output logic            rx_enable_out,
   output logic            tx_ninth_out,
   output logic            baud_doubler_out,
   output logic            irq_out
);
   logic [7:0]    ctrl_bits;
   logic          mode_low_reg;
   logic          mode_high_reg;
   logic          filter_reg;
   logic          rx_enable_reg;
   logic          tx_ninth_bit_reg;
   logic          rx_ninth_reg;
   logic          tx_done_reg;
   logic          rx_done_reg;
   logic          tx_done_evt;
   logic          framing_error_flag_reg;
   logic [7:0]    node_address_reg;
   logic [7:0]    node_address_mask_reg;
   logic [1:0]    opt_reg;
   logic [2:0]    irq_status_reg;
   logic [2:0]    irq_mask_reg;
   logic [7:0]    rdata_reg;
   logic          tx_ninth_reg;
   spcf_pkg::spcf_mode_type mode;
   logic          tx_evt;
   logic          rx_evt;
   logic          rx_evt_raw;
   logic          addr_hit;
   logic          rx_accept;
   logic          rx_done_evt;
   logic          fe_evt;
   logic          ctrl_wr;
   logic [7:0]    ctrl_wmask;
   logic [7:0]    ctrl_wval;
   logic          fe_wr;
   logic          fe_wval;
   logic [7:0]    ctrl_view;
   logic [2:0]    irq_events;

   // Event strobes come from the shift datapath in the link clock; sync them
   spcf_sync u_tx_sync (
      .clock_in  (clock_in),
      .rstn_in   (rstn_in),
      .async_in  (tx_stop_start_in),
      .level_out (),
      .rise_out  (tx_evt)
   );

   spcf_sync u_rx_sync (
      .clock_in  (clock_in),
      .rstn_in   (rstn_in),
      .async_in  (rx_sample_in),
      .level_out (),
      .rise_out  (rx_evt_raw)
   );

   spcf_addr_match u_match (
      .byte_in              (rx_byte_in),
      .node_address_in      (node_address_reg),
      .node_address_mask_in (node_address_mask_reg),
      .match_out            (addr_hit)
   );

   assign mode = spcf_pkg::spcf_mode_type'({mode_low_reg, mode_high_reg});

   // Receiver dead while enable clear
   assign rx_evt = rx_evt_raw && rx_enable_reg;

   // Frame acceptance by mode and filter
   always_comb begin
      rx_accept = 1'b1;
      case (mode)
         spcf_pkg::SPCF_MODE_SHIFT: begin
            rx_accept = 1'b1;
         end
         spcf_pkg::SPCF_MODE_UART8: begin
            if (filter_reg) begin
               rx_accept = rx_stop_in && addr_hit;
            end
         end
         spcf_pkg::SPCF_MODE_UART9_FIXED,
         spcf_pkg::SPCF_MODE_UART9_VAR: begin
            if (filter_reg) begin
               rx_accept = rx_ninth_in && addr_hit;
            end
         end
         default: begin
            rx_accept = 1'b1;
         end
      endcase
   end

   // Datapath pulses rx_sample at bit 8 end in mode 0, mid stop otherwise
   assign rx_done_evt = rx_evt && rx_accept;
   // Framing check on any non-shift frame, whatever doubler or bit 7 shows
   assign fe_evt = rx_evt && (mode != spcf_pkg::SPCF_MODE_SHIFT) && !rx_stop_in;
   assign tx_done_evt = tx_evt && (mode != spcf_pkg::SPCF_MODE_SHIFT);

   // Byte write or single-bit write into the control register
   always_comb begin
      ctrl_wr    = 1'b0;
      ctrl_wmask = 8'h00;
      ctrl_wval  = wdata_in;
      if (write_in && addr_in == spcf_pkg::SPCF_CTRL_OFFSET) begin
         ctrl_wr    = 1'b1;
         ctrl_wmask = 8'hFF;
      end else if (bit_write_in) begin
         ctrl_wr    = 1'b1;
         ctrl_wmask = bit_sel_in;
      end
   end

   // Bit 7 steered by framing select
   assign fe_wr   = ctrl_wr && ctrl_wmask[7] && opt_reg[spcf_pkg::SPCF_OPT_FRAMING];
   assign fe_wval = ctrl_wval[7];

   // One flop per control bit, so each writer and each event stays apart
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mode_low_reg <= spcf_pkg::SPCF_CTRL_RESET[spcf_pkg::SPCF_BIT_MODE_LOW];
      end else if (ctrl_wr && ctrl_wmask[spcf_pkg::SPCF_BIT_MODE_LOW] &&
                   !opt_reg[spcf_pkg::SPCF_OPT_FRAMING]) begin
         mode_low_reg <= ctrl_wval[spcf_pkg::SPCF_BIT_MODE_LOW];
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mode_high_reg <= spcf_pkg::SPCF_CTRL_RESET[spcf_pkg::SPCF_BIT_MODE_HIGH];
      end else if (ctrl_wr && ctrl_wmask[spcf_pkg::SPCF_BIT_MODE_HIGH]) begin
         mode_high_reg <= ctrl_wval[spcf_pkg::SPCF_BIT_MODE_HIGH];
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         filter_reg <= spcf_pkg::SPCF_CTRL_RESET[spcf_pkg::SPCF_BIT_FILTER];
      end else if (ctrl_wr && ctrl_wmask[spcf_pkg::SPCF_BIT_FILTER]) begin
         filter_reg <= ctrl_wval[spcf_pkg::SPCF_BIT_FILTER];
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_enable_reg <= spcf_pkg::SPCF_CTRL_RESET[spcf_pkg::SPCF_BIT_RX_EN];
      end else if (ctrl_wr && ctrl_wmask[spcf_pkg::SPCF_BIT_RX_EN]) begin
         rx_enable_reg <= ctrl_wval[spcf_pkg::SPCF_BIT_RX_EN];
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_ninth_bit_reg <= spcf_pkg::SPCF_CTRL_RESET[spcf_pkg::SPCF_BIT_TX_NINTH];
      end else if (ctrl_wr && ctrl_wmask[spcf_pkg::SPCF_BIT_TX_NINTH]) begin
         tx_ninth_bit_reg <= ctrl_wval[spcf_pkg::SPCF_BIT_TX_NINTH];
      end
   end

   // Captured only on accepted frames, winning over a same-cycle write
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_ninth_reg <= spcf_pkg::SPCF_CTRL_RESET[spcf_pkg::SPCF_BIT_RX_NINTH];
      end else if (rx_done_evt && (mode == spcf_pkg::SPCF_MODE_UART9_FIXED ||
                                   mode == spcf_pkg::SPCF_MODE_UART9_VAR)) begin
         rx_ninth_reg <= rx_ninth_in;
      end else if (rx_done_evt && mode == spcf_pkg::SPCF_MODE_UART8 && !filter_reg) begin
         rx_ninth_reg <= rx_stop_in;
      end else if (ctrl_wr && ctrl_wmask[spcf_pkg::SPCF_BIT_RX_NINTH]) begin
         rx_ninth_reg <= ctrl_wval[spcf_pkg::SPCF_BIT_RX_NINTH];
      end
   end

   // Set beats a same-cycle clear
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_done_reg <= spcf_pkg::SPCF_CTRL_RESET[spcf_pkg::SPCF_BIT_TX_DONE];
      end else if (tx_done_evt) begin
         tx_done_reg <= 1'b1;
      end else if (ctrl_wr && ctrl_wmask[spcf_pkg::SPCF_BIT_TX_DONE]) begin
         tx_done_reg <= ctrl_wval[spcf_pkg::SPCF_BIT_TX_DONE];
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_done_reg <= spcf_pkg::SPCF_CTRL_RESET[spcf_pkg::SPCF_BIT_RX_DONE];
      end else if (rx_done_evt) begin
         rx_done_reg <= 1'b1;
      end else if (ctrl_wr && ctrl_wmask[spcf_pkg::SPCF_BIT_RX_DONE]) begin
         rx_done_reg <= ctrl_wval[spcf_pkg::SPCF_BIT_RX_DONE];
      end
   end

   assign ctrl_bits = {mode_low_reg, mode_high_reg, filter_reg, rx_enable_reg,
                       tx_ninth_bit_reg, rx_ninth_reg, tx_done_reg, rx_done_reg};

   // Only a software zero clears it; set wins the tie
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         framing_error_flag_reg <= 1'b0;
      end else if (fe_evt) begin
         framing_error_flag_reg <= 1'b1;
      end else if (fe_wr) begin
         framing_error_flag_reg <= fe_wval;
      end
   end

   // Address pair feeds the matcher directly; a change applies to the next frame
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         node_address_reg <= spcf_pkg::SPCF_ADDR_RESET;
      end else if (write_in && addr_in == spcf_pkg::SPCF_ADDR_OFFSET) begin
         node_address_reg <= wdata_in;
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         node_address_mask_reg <= spcf_pkg::SPCF_MASK_RESET;
      end else if (write_in && addr_in == spcf_pkg::SPCF_MASK_OFFSET) begin
         node_address_mask_reg <= wdata_in;
      end
   end

   // Framing select only steers bit 7; the detector never looks at it
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         opt_reg <= spcf_pkg::SPCF_OPT_RESET;
      end else if (write_in && addr_in == spcf_pkg::SPCF_OPT_OFFSET) begin
         opt_reg <= wdata_in[1:0];
      end
   end

   // Mask only gates the output, so masked events still latch
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_mask_reg <= spcf_pkg::SPCF_IRQ_RESET;
      end else if (write_in && addr_in == spcf_pkg::SPCF_IRQ_MSK_OFFSET) begin
         irq_mask_reg <= wdata_in[2:0];
      end
   end

   // Sticky events, write one to clear, set wins
   assign irq_events = {fe_evt,
                        rx_done_evt,
                        tx_evt && mode != spcf_pkg::SPCF_MODE_SHIFT};

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_status_reg <= spcf_pkg::SPCF_IRQ_RESET;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (irq_events[i]) begin
               irq_status_reg[i] <= 1'b1;
            end else if (write_in && addr_in == spcf_pkg::SPCF_IRQ_ST_OFFSET && wdata_in[i]) begin
               irq_status_reg[i] <= 1'b0;
            end
         end
      end
   end

   assign irq_out = |(irq_status_reg & irq_mask_reg);

   // Bit 7 view depends on framing select
   always_comb begin
      ctrl_view = ctrl_bits;
      if (opt_reg[spcf_pkg::SPCF_OPT_FRAMING]) begin
         ctrl_view[7] = framing_error_flag_reg;
      end
   end

   // Unmapped reads return zero
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_reg <= 8'h00;
      end else if (read_in) begin
         case (addr_in)
            spcf_pkg::SPCF_CTRL_OFFSET:    rdata_reg <= ctrl_view;
            spcf_pkg::SPCF_ADDR_OFFSET:    rdata_reg <= node_address_reg;
            spcf_pkg::SPCF_MASK_OFFSET:    rdata_reg <= node_address_mask_reg;
            spcf_pkg::SPCF_OPT_OFFSET:     rdata_reg <= {6'h00, opt_reg};
            spcf_pkg::SPCF_IRQ_ST_OFFSET:  rdata_reg <= {5'h00, irq_status_reg};
            spcf_pkg::SPCF_IRQ_MSK_OFFSET: rdata_reg <= {5'h00, irq_mask_reg};
            default:                       rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // Ninth bit held only in 9-bit modes
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_ninth_reg <= 1'b0;
      end else if (mode == spcf_pkg::SPCF_MODE_UART9_FIXED ||
                   mode == spcf_pkg::SPCF_MODE_UART9_VAR) begin
         tx_ninth_reg <= tx_ninth_bit_reg;
      end else begin
         tx_ninth_reg <= 1'b0;
      end
   end

   assign rdata_out        = rdata_reg;
   assign mode_out         = mode;
   assign rx_enable_out    = rx_enable_reg;
   assign tx_ninth_out     = tx_ninth_reg;
   assign baud_doubler_out = opt_reg[spcf_pkg::SPCF_OPT_DOUBLER];
endmodule : spcf_core

// file: logic/spcf_pkg.sv
package spcf_pkg;
   localparam logic [7:0] SPCF_CTRL_OFFSET    = 8'h98;
   localparam logic [7:0] SPCF_ADDR_OFFSET    = 8'hA9;
   localparam logic [7:0] SPCF_MASK_OFFSET    = 8'hB9;
   localparam logic [7:0] SPCF_OPT_OFFSET     = 8'h87;
   localparam logic [7:0] SPCF_IRQ_ST_OFFSET  = 8'hC0;
   localparam logic [7:0] SPCF_IRQ_MSK_OFFSET = 8'hC1;
   localparam logic [7:0] SPCF_CTRL_RESET     = 8'h00;
   localparam logic [7:0] SPCF_ADDR_RESET     = 8'h00;
   localparam logic [7:0] SPCF_MASK_RESET     = 8'h00;
   localparam logic [1:0] SPCF_OPT_RESET      = 2'h0;
   localparam logic [2:0] SPCF_IRQ_RESET      = 3'h0;
   localparam int SPCF_BIT_MODE_LOW  = 7;
   localparam int SPCF_BIT_MODE_HIGH = 6;
   localparam int SPCF_BIT_FILTER    = 5;
   localparam int SPCF_BIT_RX_EN     = 4;
   localparam int SPCF_BIT_TX_NINTH  = 3;
   localparam int SPCF_BIT_RX_NINTH  = 2;
   localparam int SPCF_BIT_TX_DONE   = 1;
   localparam int SPCF_BIT_RX_DONE   = 0;
   localparam int SPCF_OPT_FRAMING   = 1;
   localparam int SPCF_OPT_DOUBLER   = 0;
   localparam int SPCF_IRQ_TX        = 0;
   localparam int SPCF_IRQ_RX        = 1;
   localparam int SPCF_IRQ_FE        = 2;
   typedef enum logic [1:0] {
      SPCF_MODE_SHIFT,
      SPCF_MODE_UART8,
      SPCF_MODE_UART9_FIXED,
      SPCF_MODE_UART9_VAR
   } spcf_mode_type;
endpackage : spcf_pkg

// file: logic/spcf_sync.sv
`timescale 1ns/10ps
module spcf_sync (
   input  wire logic clock_in,
   input  wire logic rstn_in,
   input  wire logic async_in,
   output logic      level_out,
   output logic      rise_out
);
   logic [2:0] stage_reg;
   logic       level_reg;

   // Change counts once the second and third stages agree
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stage_reg <= 3'h0;
      end else begin
         stage_reg <= {stage_reg[1:0], async_in};
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         level_reg <= 1'b0;
      end else if (stage_reg[1] == stage_reg[2]) begin
         level_reg <= stage_reg[2];
      end
   end

   assign level_out = level_reg;
   assign rise_out  = (stage_reg[1] == stage_reg[2]) && stage_reg[2] && !level_reg;
endmodule : spcf_sync

// file: verif/spcf_core_bench.sv
`timescale 1ns/10ps
module spcf_core_bench;
   localparam logic [7:0] CTL = spcf_pkg::SPCF_CTRL_OFFSET;
   localparam logic [7:0] STA = spcf_pkg::SPCF_IRQ_ST_OFFSET;
   localparam logic [7:0] NODE = 8'hC0;
   localparam logic [7:0] AMSK = 8'hFD;
   localparam logic [7:0] REGS [6] = '{CTL, spcf_pkg::SPCF_ADDR_OFFSET,
      spcf_pkg::SPCF_MASK_OFFSET, spcf_pkg::SPCF_OPT_OFFSET, STA, spcf_pkg::SPCF_IRQ_MSK_OFFSET};
   localparam logic [7:0] PICK [4] = '{8'hC2, 8'hC0, 8'hFF, 8'hC1};
   logic       clock_in, rstn_in, write_in, read_in, bit_write_in, tx_stop_start_in;
   logic [7:0] addr_in, wdata_in, bit_sel_in, rdata_out, rx_byte_in;
   logic [1:0] mode_out;
   logic       rx_enable_out, tx_ninth_out, baud_doubler_out, irq_out;
   logic       rx_sample_in, rx_ninth_in, rx_stop_in;
   int         fail_count;
   int         cmp_count;
   spcf_core spcf_core_i (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .bit_sel_in(bit_sel_in),
      .bit_write_in(bit_write_in), .rdata_out(rdata_out), .tx_stop_start_in(tx_stop_start_in),
      .rx_sample_in(rx_sample_in), .rx_byte_in(rx_byte_in), .rx_ninth_in(rx_ninth_in),
      .rx_stop_in(rx_stop_in), .mode_out(mode_out), .rx_enable_out(rx_enable_out),
      .tx_ninth_out(tx_ninth_out), .baud_doubler_out(baud_doubler_out), .irq_out(irq_out));
   spcf_node spcf_node_i (.clock_in(clock_in), .sample_out(rx_sample_in),
      .byte_out(rx_byte_in), .ninth_out(rx_ninth_in), .stop_out(rx_stop_in));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {addr_in, wdata_in, write_in} <= {a, d, 1'h1};
      @(posedge clock_in);
      write_in <= 1'h0;
      @(posedge clock_in);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                     input string nm);
      {addr_in, read_in} <= {a, 1'h1};
      @(posedge clock_in);
      read_in <= 1'h0;
      // Read data stand only in this cycle; look mid-cycle, clear of the edge
      @(negedge clock_in);
      chk(nm, e & m, rdata_out & m);
      @(posedge clock_in);
   endtask : rc
   task automatic irq_is(input logic e);
      @(posedge clock_in);
      chk("irq", {7'h00, e}, {7'h00, irq_out});
   endtask : irq_is
   // Acceptance of a frame with receive enabled
   function automatic logic acc(input logic [1:0] m, input logic f, input logic [7:0] b,
                                input logic n);
      logic hit;
      hit = ((b ^ NODE) & AMSK) == 8'h00 || (b | ~(NODE | AMSK)) == 8'hFF;
      return m == 2'h0 || !f || (hit && (m[1] ? n : 1'h1));
   endfunction : acc
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   initial begin
      clock_in = 1'h0;
      forever #2.5 clock_in = ~clock_in;
   end
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
   initial begin
      logic [7:0] d, b;
      logic [1:0] m;
      logic       f, r, n, a;
      {addr_in, wdata_in, bit_sel_in} = 24'h000000;
      {write_in, read_in, bit_write_in, tx_stop_start_in, rstn_in} = 5'h00;
      {fail_count, cmp_count} = {0, 0};
      d = 8'($urandom(33));
      repeat (8) @(posedge clock_in);
      rstn_in <= 1'h1;
      @(posedge clock_in);
      foreach (REGS[i]) begin
         rc(REGS[i], 8'hFF, 8'h00, "reset");
      end
      wr(8'h00, 8'hFF);
      rc(8'h00, 8'hFF, 8'h00, "unmapped");
      wr(spcf_pkg::SPCF_MASK_OFFSET, AMSK);
      wr(spcf_pkg::SPCF_ADDR_OFFSET, NODE);
      rc(spcf_pkg::SPCF_ADDR_OFFSET, 8'hFF, NODE, "node");
      for (int i = 0; i < 5; i++) begin
         d = (i == 0) ? 8'hF8 : 8'($urandom) & 8'hF8;
         wr(CTL, d);
         rc(CTL, 8'hFF, d, "ctrl");
         chk("tx9", {7'h00, d[3] & d[7]}, {7'h00, tx_ninth_out});
      end
      // Stop bit stays valid here so framing never muddies acceptance
      for (int i = 0; i < 16; i++) begin
         {m, f, r, n} = 5'($urandom);
         b = $urandom_range(1) ? PICK[$urandom_range(3)] : 8'($urandom);
         wr(CTL, {m, f, r | i[0], 4'h0});
         spcf_node_i.frame(b, n, 1'h1);
         a = (r | i[0]) && acc(m, f, b, n);
         rc(CTL, 8'hFF,
            {m, f, r | i[0], 1'h0, a && (m[1] ? n : m[0] && !f), 1'h0, a}, "rx");
         rc(STA, 8'hFF, {6'h00, a, 1'h0}, "rxirq");
         wr(STA, 8'h07);
      end
      wr(CTL, 8'h50);
      wr(spcf_pkg::SPCF_OPT_OFFSET, 8'h03);
      chk("dbl", 8'h01, {7'h00, baud_doubler_out});
      spcf_node_i.frame(8'h3C, 1'h0, 1'h0);
      rc(CTL, 8'hFF, 8'hD1, "fe");
      chk("mode", 8'h01, {6'h00, mode_out});
      {bit_sel_in, wdata_in, bit_write_in} <= {8'h11, 8'h10, 1'h1};
      @(posedge clock_in);
      bit_write_in <= 1'h0;
      @(posedge clock_in);
      rc(CTL, 8'hFF, 8'hD0, "bitclr");
      spcf_node_i.frame(8'h3C, 1'h0, 1'h1);
      rc(CTL, 8'hFF, 8'hD5, "fekeep");
      rc(STA, 8'hFF, 8'h06, "irqst");
      wr(spcf_pkg::SPCF_IRQ_MSK_OFFSET, 8'h04);
      irq_is(1'h1);
      wr(STA, 8'h04);
      irq_is(1'h0);
      wr(spcf_pkg::SPCF_IRQ_MSK_OFFSET, 8'h00);
      wr(CTL, 8'h50);
      rc(CTL, 8'hFB, 8'h50, "feclr");
      spcf_node_i.frame(8'h3C, 1'h0, 1'h0);
      wr(spcf_pkg::SPCF_OPT_OFFSET, 8'h00);
      rc(CTL, 8'hFB, 8'h51, "bit7");
      for (int i = 0; i < 2; i++) begin
         d = {1'h0, i[0], 6'h00};
         wr(CTL, d);
         tx_stop_start_in <= 1'h1;
         repeat (5) @(posedge clock_in);
         tx_stop_start_in <= 1'h0;
         repeat (5) @(posedge clock_in);
         rc(CTL, 8'hFB, d | {6'h00, i[0], 1'h0}, "tx");
      end
      summarize();
   end
endmodule : spcf_core_bench

// file: verif/spcf_monitor.sv
`timescale 1ns/10ps
module spcf_monitor (
   input wire logic       clock_in,
   input wire logic       rstn_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       write_in,
   input wire logic       read_in,
   input wire logic [7:0] bit_sel_in,
   input wire logic       bit_write_in,
   input wire logic [7:0] rdata_out,
   input wire logic [1:0] mode_out,
   input wire logic       rx_enable_out,
   input wire logic       tx_ninth_out,
   input wire logic       baud_doubler_out
);
   logic fsel_reg;
   logic wr_ctl;
   assign wr_ctl = write_in && addr_in == spcf_pkg::SPCF_CTRL_OFFSET;
   // Bit 7 routing hangs on this hidden option bit
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fsel_reg <= 1'h0;
      end else if (write_in && addr_in == spcf_pkg::SPCF_OPT_OFFSET) begin
         fsel_reg <= wdata_in[1];
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   property p_tx9; !mode_out[1] && !$past(mode_out[1]) |-> !tx_ninth_out; endproperty
   a_tx9: assert property (p_tx9) else $error("ninth bit sent in 8-bit mode");
   property p_ren; wr_ctl |=> rx_enable_out == $past(wdata_in[4]); endproperty
   a_ren: assert property (p_ren) else $error("receive enable not written");
   property p_rbw; bit_write_in && bit_sel_in[4] |=> rx_enable_out == $past(wdata_in[4]);
   endproperty
   a_rbw: assert property (p_rbw) else $error("single bit write lost");
   property p_mhi; wr_ctl |=> mode_out[0] == $past(wdata_in[6]); endproperty
   a_mhi: assert property (p_mhi) else $error("mode high not written");
   property p_mlo; wr_ctl && !fsel_reg |=> mode_out[1] == $past(wdata_in[7]); endproperty
   a_mlo: assert property (p_mlo) else $error("mode low not written");
   property p_mkp; wr_ctl && fsel_reg |=> $stable(mode_out[1]); endproperty
   a_mkp: assert property (p_mkp) else $error("mode low hit by flag write");
   property p_adr; write_in && addr_in == spcf_pkg::SPCF_ADDR_OFFSET ##2
      read_in && addr_in == spcf_pkg::SPCF_ADDR_OFFSET |=> rdata_out == $past(wdata_in, 3);
   endproperty
   a_adr: assert property (p_adr) else $error("node address readback");
   property p_dbl; write_in && addr_in == spcf_pkg::SPCF_OPT_OFFSET
      |=> baud_doubler_out == $past(wdata_in[0]); endproperty
   a_dbl: assert property (p_dbl) else $error("doubler not written");
endmodule : spcf_monitor
bind spcf_core spcf_monitor spcf_monitor_i (.clock_in(clock_in), .rstn_in(rstn_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
   .bit_sel_in(bit_sel_in), .bit_write_in(bit_write_in), .rdata_out(rdata_out),
   .mode_out(mode_out), .rx_enable_out(rx_enable_out), .tx_ninth_out(tx_ninth_out),
   .baud_doubler_out(baud_doubler_out));

// file: verif/spcf_node.sv
`timescale 1ns/10ps
module spcf_node (
   input  wire logic  clock_in,
   output logic       sample_out,
   output logic [7:0] byte_out,
   output logic       ninth_out,
   output logic       stop_out
);
   initial begin
      sample_out = 1'h0;
      {byte_out, ninth_out, stop_out} = 10'h001;
   end
   // Fields go stale after the pulse so no old value passes as fresh
   task automatic frame(input logic [7:0] b, input logic n, input logic s);
      {byte_out, ninth_out, stop_out} <= {b, n, s};
      sample_out <= 1'h1;
      repeat (5) @(posedge clock_in);
      sample_out <= 1'h0;
      repeat (5) @(posedge clock_in);
      {byte_out, ninth_out, stop_out} <= ~{b, n, s};
   endtask : frame
endmodule : spcf_node
